// >>> common/deac_pkg.sv
package deac_pkg;

   // Sector-1 offsets of the four access registers.
   localparam logic [7:0] DEAC_OFF_CTRL = 8'h40;
   localparam logic [7:0] DEAC_OFF_ADDR_LOW = 8'h41;
   localparam logic [7:0] DEAC_OFF_ADDR_HIGH = 8'h42;
   localparam logic [7:0] DEAC_OFF_DATA = 8'h43;

   localparam int DEAC_DEPTH = 512;
   localparam int DEAC_AW = 9;
   localparam int DEAC_PAGE = 16;
   localparam logic [3:0] DEAC_PAGE_LAST = 4'hF;
   localparam logic [7:0] DEAC_ZERO_BYTE = 8'h00;
   localparam logic [8:0] DEAC_ADDR_RST = 9'h000;
   localparam logic [15:0] DEAC_TAG_NONE = 16'h0000;

   // Cycle times in microseconds and the clock rate in kHz.
   localparam int DEAC_CLK_KHZ = 40000;
   localparam int DEAC_ERASE_FAST_US = 3200;
   localparam int DEAC_WRITE_FAST_US = 2200;
   localparam int DEAC_ERASE_SLOW_US = 3700;
   localparam int DEAC_WRITE_SLOW_US = 3000;
   localparam int DEAC_ERASE_FAST_CYC = DEAC_ERASE_FAST_US * DEAC_CLK_KHZ / 1000;
   localparam int DEAC_WRITE_FAST_CYC = DEAC_WRITE_FAST_US * DEAC_CLK_KHZ / 1000;
   localparam int DEAC_ERASE_SLOW_CYC = DEAC_ERASE_SLOW_US * DEAC_CLK_KHZ / 1000;
   localparam int DEAC_WRITE_SLOW_CYC = DEAC_WRITE_SLOW_US * DEAC_CLK_KHZ / 1000;
   localparam int DEAC_READ_CYC = 2;
   localparam int DEAC_TW = 18;

   typedef logic [DEAC_TW-1:0] deac_timer_t;

   // Control register, bit 7 down to bit 0.
   typedef struct packed {
      logic slow_cycle_sel;
      logic purge_arm;
      logic purge_go;
      logic page_mode;
      logic program_arm;
      logic program_go;
      logic fetch_arm;
      logic fetch_go;
   } deac_ctrl_t;

   localparam deac_ctrl_t DEAC_CTRL_RST = 8'h00;

   // One sector-1 access from the processor.
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } deac_req_t;

   typedef enum logic {
      DEAC_ST_IDLE = 1'b0,
      DEAC_ST_RUN = 1'b1
   } deac_state_t;

   typedef enum logic [1:0] {
      DEAC_OP_READ = 2'h0,
      DEAC_OP_WRITE = 2'h1,
      DEAC_OP_ERASE = 2'h2
   } deac_op_t;

endpackage : deac_pkg

// >>> core/deac_ctrl.sv
`timescale 1ns/1ps
module deac_ctrl
   import deac_pkg::*;
#(
   parameter int ERASE_FAST_CYC = DEAC_ERASE_FAST_CYC,
   parameter int WRITE_FAST_CYC = DEAC_WRITE_FAST_CYC,
   parameter int ERASE_SLOW_CYC = DEAC_ERASE_SLOW_CYC,
   parameter int WRITE_SLOW_CYC = DEAC_WRITE_SLOW_CYC
) (
   // Clock, reset and enable
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Sector-1 indirect access port
   input wire logic sec1_wr,
   input wire logic [7:0] sec1_addr,
   input wire logic [7:0] sec1_wdata,
   output logic [7:0] sec1_rdata,
   // Status
   output logic busy
);

   deac_req_t req;
   deac_ctrl_t ctrl_q, ctrl_d, wctrl;
   logic [DEAC_AW-1:0] addr_q, addr_d;
   logic [7:0] data_q, data_d, rdata_q, rdata_d;
   logic [7:0] pbuf_q [DEAC_PAGE], pbuf_d [DEAC_PAGE];
   logic [DEAC_PAGE-1:0] ptag_q, ptag_d;
   logic fresh_w_q, fresh_w_d, fresh_e_q, fresh_e_d;
   deac_state_t state_q, state_d;
   deac_op_t op_q, op_d;
   deac_timer_t timer_q, timer_d;
   logic wr_en, done;
   logic [7:0] mem [DEAC_DEPTH];

   assign req = '{wr: sec1_wr, addr: sec1_addr, wdata: sec1_wdata};
   assign wctrl = deac_ctrl_t'(req.wdata);
   // Register writes are dropped while a cycle runs, so the address and data
   // under commit cannot change beneath it.
   assign wr_en = req.wr && (state_q == DEAC_ST_IDLE);
   assign done = (state_q == DEAC_ST_RUN) && (timer_q == '0);

   always_comb begin
      ctrl_d = ctrl_q;
      addr_d = addr_q;
      data_d = data_q;
      pbuf_d = pbuf_q;
      ptag_d = ptag_q;
      state_d = state_q;
      op_d = op_q;
      timer_d = timer_q;
      fresh_w_d = fresh_w_q;
      fresh_e_d = fresh_e_q;
      if (wr_en) begin
         // An arm stays fresh only until the next register write.
         fresh_w_d = (req.addr == DEAC_OFF_CTRL) && wctrl.program_arm && !ctrl_q.program_arm;
         fresh_e_d = (req.addr == DEAC_OFF_CTRL) && wctrl.purge_arm && !ctrl_q.purge_arm;
         unique case (req.addr)
            DEAC_OFF_ADDR_LOW: begin
               addr_d[7:0] = req.wdata;
            end
            DEAC_OFF_ADDR_HIGH: begin
               addr_d[8] = req.wdata[0];
            end
            DEAC_OFF_DATA: begin
               data_d = req.wdata;
               if (ctrl_q.page_mode) begin
                  pbuf_d[addr_q[3:0]] = req.wdata;
                  ptag_d[addr_q[3:0]] = 1'b1;
                  if (addr_q[3:0] != DEAC_PAGE_LAST) begin
                     addr_d[3:0] = addr_q[3:0] + 4'h1;
                  end
               end
            end
            DEAC_OFF_CTRL: begin
               ctrl_d = wctrl;
               ctrl_d.purge_go = 1'b0;
               ctrl_d.program_go = 1'b0;
               ctrl_d.fetch_go = 1'b0;
               if (wctrl.purge_go && ctrl_q.purge_arm && fresh_e_q) begin
                  ctrl_d.purge_go = 1'b1;
                  ctrl_d.purge_arm = 1'b1;
                  state_d = DEAC_ST_RUN;
                  op_d = DEAC_OP_ERASE;
                  timer_d = wctrl.slow_cycle_sel ? deac_timer_t'(ERASE_SLOW_CYC - 1)
                                                 : deac_timer_t'(ERASE_FAST_CYC - 1);
               end else if (wctrl.program_go && ctrl_q.program_arm && fresh_w_q) begin
                  ctrl_d.program_go = 1'b1;
                  ctrl_d.program_arm = 1'b1;
                  state_d = DEAC_ST_RUN;
                  op_d = DEAC_OP_WRITE;
                  timer_d = wctrl.slow_cycle_sel ? deac_timer_t'(WRITE_SLOW_CYC - 1)
                                                 : deac_timer_t'(WRITE_FAST_CYC - 1);
               end else if (wctrl.fetch_go && ctrl_q.fetch_arm) begin
                  ctrl_d.fetch_go = 1'b1;
                  state_d = DEAC_ST_RUN;
                  op_d = DEAC_OP_READ;
                  timer_d = deac_timer_t'(DEAC_READ_CYC - 1);
               end
               // Dropping the erase arm empties the page buffer.
               if (ctrl_q.purge_arm && !ctrl_d.purge_arm) begin
                  ptag_d = DEAC_TAG_NONE;
               end
            end
            default: begin
            end
         endcase
      end
      if (state_q == DEAC_ST_RUN) begin
         if (!done) begin
            timer_d = timer_q - deac_timer_t'(1);
         end else begin
            state_d = DEAC_ST_IDLE;
            unique case (op_q)
               DEAC_OP_ERASE: begin
                  ctrl_d.purge_go = 1'b0;
                  ctrl_d.purge_arm = 1'b0;
                  ptag_d = DEAC_TAG_NONE;
               end
               DEAC_OP_WRITE: begin
                  ctrl_d.program_go = 1'b0;
                  ctrl_d.program_arm = 1'b0;
                  ptag_d = DEAC_TAG_NONE;
               end
               DEAC_OP_READ: begin
                  ctrl_d.fetch_go = 1'b0;
                  data_d = mem[addr_q];
                  if (ctrl_q.page_mode && addr_q[3:0] != DEAC_PAGE_LAST) begin
                     addr_d[3:0] = addr_q[3:0] + 4'h1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_comb begin
      unique case (req.addr)
         DEAC_OFF_CTRL: rdata_d = ctrl_q;
         DEAC_OFF_ADDR_LOW: rdata_d = addr_q[7:0];
         DEAC_OFF_ADDR_HIGH: rdata_d = {7'h00, addr_q[8]};
         DEAC_OFF_DATA: rdata_d = data_q;
         default: rdata_d = DEAC_ZERO_BYTE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= DEAC_CTRL_RST;
         addr_q <= DEAC_ADDR_RST;
         data_q <= DEAC_ZERO_BYTE;
         ptag_q <= DEAC_TAG_NONE;
         state_q <= DEAC_ST_IDLE;
         op_q <= DEAC_OP_READ;
         timer_q <= '0;
         fresh_w_q <= 1'b0;
         fresh_e_q <= 1'b0;
         rdata_q <= DEAC_ZERO_BYTE;
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         data_q <= data_d;
         ptag_q <= ptag_d;
         state_q <= state_d;
         op_q <= op_d;
         timer_q <= timer_d;
         fresh_w_q <= fresh_w_d;
         fresh_e_q <= fresh_e_d;
         rdata_q <= rdata_d;
      end
   end

   // Buffer contents need no reset; the tags alone say what is valid.
   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         pbuf_q <= pbuf_d;
      end
   end

   // Commit into the array. A page erase clears all sixteen bytes of the page,
   // a page write stores only the tagged slots.
   always_ff @(posedge ref_clk) begin
      if (clk_en && done && op_q != DEAC_OP_READ) begin
         if (!ctrl_q.page_mode) begin
            mem[addr_q] <= (op_q == DEAC_OP_ERASE) ? DEAC_ZERO_BYTE : data_q;
         end else begin
            for (int i = 0; i < DEAC_PAGE; i++) begin
               if (op_q == DEAC_OP_ERASE) begin
                  mem[{addr_q[8:4], 4'(i)}] <= DEAC_ZERO_BYTE;
               end else if (ptag_q[i]) begin
                  mem[{addr_q[8:4], 4'(i)}] <= pbuf_q[i];
               end
            end
         end
      end
   end

   assign sec1_rdata = rdata_q;
   assign busy = (state_q == DEAC_ST_RUN);

   property p_high_addr_zero;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && req.addr == DEAC_OFF_ADDR_HIGH) |=> (sec1_rdata[7:1] == 7'h00);
   endproperty
   a_high_addr_zero: assert property (p_high_addr_zero) else $error("high address upper bits not zero");

   property p_write_fast_time;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && state_q == DEAC_ST_IDLE && state_d == DEAC_ST_RUN && op_d == DEAC_OP_WRITE && !wctrl.slow_cycle_sel)
         |=> (timer_q == deac_timer_t'(WRITE_FAST_CYC - 1));
   endproperty
   a_write_fast_time: assert property (p_write_fast_time) else $error("fast write time wrong");

   property p_erase_slow_time;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && state_q == DEAC_ST_IDLE && state_d == DEAC_ST_RUN && op_d == DEAC_OP_ERASE && wctrl.slow_cycle_sel)
         |=> (timer_q == deac_timer_t'(ERASE_SLOW_CYC - 1)) && ctrl_q.purge_go;
   endproperty
   a_erase_slow_time: assert property (p_erase_slow_time) else $error("slow erase time wrong");

   property p_purge_needs_arm;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && wr_en && req.addr == DEAC_OFF_CTRL && !ctrl_q.purge_arm && !wctrl.program_go && !wctrl.fetch_go)
         |=> (state_q == DEAC_ST_IDLE) && !ctrl_q.purge_go;
   endproperty
   a_purge_needs_arm: assert property (p_purge_needs_arm) else $error("erase started without arm");

   property p_program_needs_fresh;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && wr_en && req.addr == DEAC_OFF_CTRL && !(ctrl_q.program_arm && fresh_w_q)
         && !wctrl.purge_go && !wctrl.fetch_go)
         |=> (state_q == DEAC_ST_IDLE) && !ctrl_q.program_go;
   endproperty
   a_program_needs_fresh: assert property (p_program_needs_fresh) else $error("write started without fresh arm");

   property p_write_end;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && done && op_q == DEAC_OP_WRITE) |=> !ctrl_q.program_arm && !ctrl_q.program_go && !busy;
   endproperty
   a_write_end: assert property (p_write_end) else $error("write end did not clear bits");

   property p_erase_end;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && done && op_q == DEAC_OP_ERASE) |=> !ctrl_q.purge_arm && !ctrl_q.purge_go && ptag_q == DEAC_TAG_NONE;
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("erase end did not clear bits");

   property p_read_end;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && done && op_q == DEAC_OP_READ) |=> !ctrl_q.fetch_go && (data_q == $past(data_d));
   endproperty
   a_read_end: assert property (p_read_end) else $error("read end wrong");

   property p_read_length;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && state_q == DEAC_ST_IDLE && state_d == DEAC_ST_RUN && op_d == DEAC_OP_READ)
         ##1 clk_en [*2] |=> (state_q == DEAC_ST_IDLE) && !ctrl_q.fetch_go;
   endproperty
   a_read_length: assert property (p_read_length) else $error("read cycle length wrong");

   property p_erase_fast_time;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && state_q == DEAC_ST_IDLE && state_d == DEAC_ST_RUN && op_d == DEAC_OP_ERASE && !wctrl.slow_cycle_sel)
         |=> (timer_q == deac_timer_t'(ERASE_FAST_CYC - 1)) && ctrl_q.purge_go;
   endproperty
   a_erase_fast_time: assert property (p_erase_fast_time) else $error("fast erase time wrong");

   property p_write_slow_time;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && state_q == DEAC_ST_IDLE && state_d == DEAC_ST_RUN && op_d == DEAC_OP_WRITE && wctrl.slow_cycle_sel)
         |=> (timer_q == deac_timer_t'(WRITE_SLOW_CYC - 1)) && ctrl_q.program_go;
   endproperty
   a_write_slow_time: assert property (p_write_slow_time) else $error("slow write time wrong");

   property p_fetch_needs_arm;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && wr_en && req.addr == DEAC_OFF_CTRL && !ctrl_q.fetch_arm && !wctrl.purge_go && !wctrl.program_go)
         |=> (state_q == DEAC_ST_IDLE) && !ctrl_q.fetch_go;
   endproperty
   a_fetch_needs_arm: assert property (p_fetch_needs_arm) else $error("read started without arm");

   // A low enable must hold the timer, so a frozen cycle keeps its full length.
   property p_frozen;
      @(posedge ref_clk) disable iff (!arst_n)
      !clk_en |=> (timer_q == $past(timer_q)) && (state_q == $past(state_q)) && (ctrl_q == $past(ctrl_q));
   endproperty
   a_frozen: assert property (p_frozen) else $error("state moved while enable low");

endmodule : deac_ctrl

// >>> sim/deac_ctrl_tb_top.sv
`timescale 1ns/1ps
module deac_ctrl_tb_top;
   import deac_pkg::*;

   localparam int EF = 20;
   localparam int WF = 15;
   localparam int ES = 25;
   localparam int WS = 18;

   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   logic sec1_wr = 1'b0;
   logic [7:0] sec1_addr = 8'h00;
   logic [7:0] sec1_wdata = 8'h00;
   logic [7:0] sec1_rdata;
   logic busy;
   int fail_count = 0;
   int checks = 0;

   // The clock enable drops only in the freeze scenario, where it must stretch a running cycle.
   deac_ctrl #(.ERASE_FAST_CYC(EF), .WRITE_FAST_CYC(WF), .ERASE_SLOW_CYC(ES), .WRITE_SLOW_CYC(WS))
   deac_ctrl_inst (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .sec1_wr(sec1_wr),
      .sec1_addr(sec1_addr),
      .sec1_wdata(sec1_wdata),
      .sec1_rdata(sec1_rdata),
      .busy(busy)
   );

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic results;
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic chk_cnt(input int got, input int exp, input string what);
      checks++;
      if (got != exp) begin
         fail_count++;
         $display("Error at %0t: %s lasted %0d cycles, expected %0d", $time, what, got, exp);
      end
   endtask : chk_cnt

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sec1_wr <= 1'b1;
      sec1_addr <= a;
      sec1_wdata <= d;
      @(posedge ref_clk);
      sec1_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge ref_clk);
      sec1_addr <= a;
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
      chk8(sec1_rdata, exp, what);
   endtask : rd

   // Counts the clock edges with busy high, whatever clk_en is; the bound keeps a stuck cycle from hanging the run.
   task automatic busy_len(input int exp, input string what);
      int n;
      n = 0;
      #1;
      while (busy === 1'b1 && n < 5000) begin
         n++;
         @(posedge ref_clk);
         #1;
      end
      chk_cnt(n, exp, what);
   endtask : busy_len

   task automatic t_reset;
      chk8({7'h00, busy}, 8'h00, "busy after reset");
      rd(DEAC_OFF_CTRL, 8'h00, "ctrl reset");
      rd(DEAC_OFF_ADDR_LOW, 8'h00, "addr low reset");
      rd(DEAC_OFF_ADDR_HIGH, 8'h00, "addr high reset");
      rd(DEAC_OFF_DATA, 8'h00, "data reset");
      $display("Test reset done");
   endtask : t_reset

   task automatic t_addr;
      wr(DEAC_OFF_ADDR_LOW, 8'hA5);
      wr(DEAC_OFF_ADDR_HIGH, 8'hFF);
      wr(8'h44, 8'h77);
      rd(DEAC_OFF_ADDR_LOW, 8'hA5, "addr low");
      rd(DEAC_OFF_ADDR_HIGH, 8'h01, "addr high");
      rd(8'h44, 8'h00, "unmapped");
      $display("Test address done");
   endtask : t_addr

   task automatic t_refuse;
      wr(DEAC_OFF_CTRL, 8'h04);
      busy_len(0, "write without arm");
      wr(DEAC_OFF_CTRL, 8'h20);
      busy_len(0, "erase without arm");
      wr(DEAC_OFF_CTRL, 8'h01);
      busy_len(0, "read without arm");
      wr(DEAC_OFF_CTRL, 8'h0C);
      busy_len(0, "arm and trigger together");
      wr(DEAC_OFF_CTRL, 8'h00);
      wr(DEAC_OFF_CTRL, 8'h08);
      wr(8'h44, 8'h00);
      wr(DEAC_OFF_CTRL, 8'h0C);
      busy_len(0, "stale arm");
      wr(DEAC_OFF_CTRL, 8'h00);
      rd(DEAC_OFF_CTRL, 8'h00, "ctrl after refusals");
      $display("Test refusal done");
   endtask : t_refuse

   task automatic set_addr(input logic [7:0] lo);
      wr(DEAC_OFF_ADDR_LOW, lo);
      wr(DEAC_OFF_ADDR_HIGH, 8'h01);
   endtask : set_addr

   task automatic fetch(input logic [7:0] m, input logic [7:0] exp);
      wr(DEAC_OFF_CTRL, m | 8'h02);
      wr(DEAC_OFF_CTRL, m | 8'h03);
      busy_len(DEAC_READ_CYC, "read cycle");
      rd(DEAC_OFF_CTRL, m | 8'h02, "read trigger cleared");
      rd(DEAC_OFF_DATA, exp, "fetched byte");
   endtask : fetch

   task automatic t_write(input logic [7:0] sel, input int n, input logic [7:0] d);
      set_addr(8'h23);
      wr(DEAC_OFF_DATA, d);
      wr(DEAC_OFF_CTRL, sel | 8'h08);
      wr(DEAC_OFF_CTRL, sel | 8'h0C);
      busy_len(n, "write cycle");
      rd(DEAC_OFF_CTRL, sel, "write arm and trigger cleared");
      wr(DEAC_OFF_DATA, 8'h00);
      fetch(sel, d);
      $display("Test write done");
   endtask : t_write

   task automatic t_erase(input logic [7:0] sel, input int n);
      set_addr(8'h20);
      wr(DEAC_OFF_CTRL, sel | 8'h10);
      wr(DEAC_OFF_CTRL, sel | 8'h50);
      wr(DEAC_OFF_CTRL, sel | 8'h70);
      busy_len(n, "erase cycle");
      rd(DEAC_OFF_CTRL, sel | 8'h10, "erase arm and trigger cleared");
      // A data write in page mode steps the address, so the data register is dirtied first.
      wr(DEAC_OFF_DATA, 8'hFF);
      set_addr(8'h23);
      fetch(sel | 8'h10, 8'h00);
      rd(DEAC_OFF_ADDR_LOW, 8'h24, "page read step");
      wr(DEAC_OFF_CTRL, 8'h00);
      $display("Test erase done");
   endtask : t_erase

   // The low nibble must stop at the last slot of the 16-byte page.
   task automatic t_page_edge;
      set_addr(8'h2E);
      fetch(8'h10, 8'h00);
      rd(DEAC_OFF_ADDR_LOW, 8'h2F, "page step to end");
      fetch(8'h10, 8'h00);
      rd(DEAC_OFF_ADDR_LOW, 8'h2F, "page saturates");
      rd(DEAC_OFF_ADDR_HIGH, 8'h01, "page high kept");
      wr(DEAC_OFF_CTRL, 8'h00);
      $display("Test page boundary done");
   endtask : t_page_edge

   task automatic t_page_write;
      set_addr(8'h40);
      wr(DEAC_OFF_CTRL, 8'h10);
      wr(DEAC_OFF_DATA, 8'hAA);
      wr(DEAC_OFF_DATA, 8'hBB);
      rd(DEAC_OFF_ADDR_LOW, 8'h42, "page fill step");
      wr(DEAC_OFF_CTRL, 8'h18);
      wr(DEAC_OFF_CTRL, 8'h1C);
      busy_len(WF, "page write cycle");
      set_addr(8'h40);
      fetch(8'h10, 8'hAA);
      fetch(8'h10, 8'hBB);
      wr(DEAC_OFF_CTRL, 8'h00);
      $display("Test page write done");
   endtask : t_page_write

   // Five frozen edges must stretch the write by five cycles; a reset mid-cycle must abort it.
   task automatic t_freeze_reset;
      set_addr(8'h30);
      wr(DEAC_OFF_DATA, 8'h96);
      wr(DEAC_OFF_CTRL, 8'h08);
      wr(DEAC_OFF_CTRL, 8'h0C);
      clk_en <= 1'b0;
      repeat (5) @(posedge ref_clk);
      clk_en <= 1'b1;
      busy_len(WF, "frozen write cycle");
      wr(DEAC_OFF_CTRL, 8'h08);
      wr(DEAC_OFF_CTRL, 8'h8C);
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b0;
      @(posedge ref_clk);
      chk8({7'h00, busy}, 8'h00, "busy in reset");
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd(DEAC_OFF_CTRL, 8'h00, "ctrl after mid reset");
      rd(DEAC_OFF_DATA, 8'h00, "data after mid reset");
      set_addr(8'h30);
      fetch(8'h00, 8'h96);
      wr(DEAC_OFF_CTRL, 8'h40);
      wr(DEAC_OFF_CTRL, 8'h60);
      busy_len(EF, "byte erase cycle");
      fetch(8'h00, 8'h00);
      $display("Test freeze and reset done");
   endtask : t_freeze_reset

   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_addr();
      t_refuse();
      t_write(8'h00, WF, 8'h5A);
      t_erase(8'h00, EF);
      t_write(8'h80, WS, 8'hC3);
      t_erase(8'h80, ES);
      t_page_edge();
      t_page_write();
      t_freeze_reset();
      results();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      results();
   end

endmodule : deac_ctrl_tb_top
